// file: common/pwr_pkg.sv
package pwr_pkg;

  // Number of peripheral slots under suspend and clock control.
  localparam int unsigned NUM_PERIPH = 8;

  // Encoded software mode request and reported mode.
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_DEEP = 2'h3;

  // Clock source selections.
  localparam logic [1:0] SRC_DIRECT = 2'h0;
  localparam logic [1:0] SRC_PLL = 2'h1;
  localparam logic [1:0] SRC_PRESCALE = 2'h2;

  // System clock rate and handover settling time.
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned SETTLE_NS = 200;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC);

  // Reset value of the clock settle counter.
  localparam logic [3:0] STEP_RST = 4'h0;

  // Power-mode state machine states.
  typedef enum logic [3:0] {
    PM_RUN, PM_IDLE, PM_SUS, PM_GATE, PM_SLEEP, PM_DEEP, PM_UNGATE, PM_RESUME
  } pm_state_t;

  // Clock generation unit switching states.
  typedef enum logic [2:0] {
    CK_RUN, CK_HOLD, CK_SWITCH, CK_SETTLE, CK_EMERG
  } ck_state_t;

  // Wake event group.
  typedef struct packed {
    logic nmi_n;
    logic watchdog;
    logic ext_wake;
    logic irq_any;
    logic [NUM_PERIPH-1:0] irq_periph;
  } wake_t;

  // Peripheral control group.
  typedef struct packed {
    logic [NUM_PERIPH-1:0] clk_en;
    logic [NUM_PERIPH-1:0] suspend;
  } periph_ctl_t;

endpackage

// file: logic/power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - In run mode all clocks and peripherals follow the software configuration.
// - A software idle request stops the processor clock until a wake condition.
// - In idle every enabled peripheral stays clocked and may still reach processor memory.
// - Idle wakes on reset, watchdog event, NMI falling edge or any enabled interrupt.
// - In sleep only peripherals marked for sleep keep their clock; the rest are suspended.
// - Sleep wakes on a running peripheral's interrupt, watchdog, NMI falling edge or reset.
// - Sleep and deep sleep are entered through an ordered shut-down sequence.
// - Deep sleep stops the system clock and only an external signal restarts it.
// - In run mode, units that are idle are gated off automatically and resume when needed.
// - The clock unit switches safely between PLL, direct and prescaled clocking.
// - A PLL monitor detects frequency deviation or clock loss and takes emergency action.
module power_mode_controller
  import pwr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mode_req,
  input wire logic [1:0] mode_sel,
  input wire logic [NUM_PERIPH-1:0] periph_en,
  input wire logic [NUM_PERIPH-1:0] sleep_en,
  input wire logic [NUM_PERIPH-1:0] periph_busy,
  input wire wake_t wake,
  input wire logic src_req,
  input wire logic [1:0] src_sel,
  input wire logic pll_locked,
  input wire logic pll_freq_bad,
  input wire logic osc_lost,
  output logic [1:0] mode_status,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output periph_ctl_t periph_ctl,
  output logic [1:0] clk_src,
  output logic clk_busy,
  output logic pll_emergency
);

  pm_state_t pm_r, pm_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic nmi_d_r, nmi_d_nxt;
  periph_ctl_t ctl_r, ctl_nxt;
  logic cpu_en_r, cpu_en_nxt;
  logic sys_en_r, sys_en_nxt;
  ck_state_t ck_r, ck_nxt;
  logic [1:0] src_r, src_nxt;
  logic [1:0] tgt_r, tgt_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic emerg_r, emerg_nxt;
  logic nmi_fall;
  logic wake_idle;
  logic wake_sleep;
  logic [NUM_PERIPH-1:0] run_clk;

  // Clock enables for run mode: configured units, gated while idle and not busy.
  function automatic logic [NUM_PERIPH-1:0] run_gate(input logic [NUM_PERIPH-1:0] en,
                                                    input logic [NUM_PERIPH-1:0] busy);
    run_gate = en & busy;
  endfunction

  // Wake decoding and NMI falling edge.
  always_comb begin
    nmi_fall = nmi_d_r & ~wake.nmi_n;
    wake_idle = wake.watchdog | nmi_fall | wake.irq_any;
    wake_sleep = wake.watchdog | nmi_fall | (|(wake.irq_periph & sleep_en));
    run_clk = run_gate(periph_en, periph_busy);
  end

  // Power-mode state machine next state.
  always_comb begin
    pm_nxt = pm_r;
    mode_nxt = mode_r;
    ctl_nxt = ctl_r;
    cpu_en_nxt = cpu_en_r;
    sys_en_nxt = sys_en_r;
    nmi_d_nxt = wake.nmi_n;
    case (pm_r)
      PM_RUN: begin
        cpu_en_nxt = 1'b1;
        sys_en_nxt = 1'b1;
        ctl_nxt.clk_en = run_clk;
        ctl_nxt.suspend = '0;
        mode_nxt = MODE_RUN;
        if (mode_req) begin
          case (mode_sel)
            MODE_IDLE: begin
              pm_nxt = PM_IDLE;
              mode_nxt = MODE_IDLE;
              cpu_en_nxt = 1'b0;
              ctl_nxt.clk_en = periph_en;
            end
            MODE_SLEEP, MODE_DEEP: begin
              pm_nxt = PM_SUS;
              mode_nxt = mode_sel;
            end
            default: pm_nxt = PM_RUN;
          endcase
        end
      end
      PM_IDLE: begin
        ctl_nxt.clk_en = periph_en;
        if (wake_idle) begin
          pm_nxt = PM_RUN;
          cpu_en_nxt = 1'b1;
        end
      end
      PM_SUS: begin
        cpu_en_nxt = 1'b0;
        ctl_nxt.suspend = (mode_r == MODE_DEEP) ? {NUM_PERIPH{1'b1}} : ~sleep_en;
        pm_nxt = PM_GATE;
      end
      PM_GATE: begin
        ctl_nxt.clk_en = (mode_r == MODE_DEEP) ? '0 : (periph_en & sleep_en);
        if (mode_r == MODE_DEEP) begin
          sys_en_nxt = 1'b0;
          pm_nxt = PM_DEEP;
        end else begin
          pm_nxt = PM_SLEEP;
        end
      end
      PM_SLEEP: begin
        if (wake_sleep) begin
          pm_nxt = PM_UNGATE;
        end
      end
      PM_DEEP: begin
        if (wake.ext_wake) begin
          sys_en_nxt = 1'b1;
          pm_nxt = PM_UNGATE;
        end
      end
      PM_UNGATE: begin
        ctl_nxt.clk_en = run_clk;
        cpu_en_nxt = 1'b1;
        pm_nxt = PM_RESUME;
      end
      PM_RESUME: begin
        ctl_nxt.suspend = '0;
        mode_nxt = MODE_RUN;
        pm_nxt = PM_RUN;
      end
      default: pm_nxt = PM_RUN;
    endcase
  end

  // Power-mode registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pm_r <= PM_RUN;
      mode_r <= MODE_RUN;
      ctl_r <= '0;
      cpu_en_r <= 1'b1;
      sys_en_r <= 1'b1;
      nmi_d_r <= 1'b1;
    end else begin
      pm_r <= pm_nxt;
      mode_r <= mode_nxt;
      ctl_r <= ctl_nxt;
      cpu_en_r <= cpu_en_nxt;
      sys_en_r <= sys_en_nxt;
      nmi_d_r <= nmi_d_nxt;
    end
  end

  // Clock source sequencer and PLL fail-safe monitor.
  always_comb begin
    ck_nxt = ck_r;
    src_nxt = src_r;
    tgt_nxt = tgt_r;
    cnt_nxt = cnt_r;
    emerg_nxt = emerg_r;
    if ((src_r == SRC_PLL) && (pll_freq_bad || osc_lost || !pll_locked)) begin
      emerg_nxt = 1'b1;
      src_nxt = SRC_PRESCALE;
      ck_nxt = CK_EMERG;
    end else begin
      case (ck_r)
        CK_RUN: begin
          if (src_req && (src_sel != src_r) && (src_sel != 2'h3)) begin
            tgt_nxt = src_sel;
            ck_nxt = CK_HOLD;
          end
        end
        CK_HOLD: begin
          if ((tgt_r != SRC_PLL) || pll_locked) begin
            ck_nxt = CK_SWITCH;
          end
        end
        CK_SWITCH: begin
          src_nxt = tgt_r;
          cnt_nxt = SETTLE_CNT;
          ck_nxt = CK_SETTLE;
        end
        CK_SETTLE: begin
          if (cnt_r <= 4'h1) begin
            cnt_nxt = STEP_RST;
            ck_nxt = CK_RUN;
          end else begin
            cnt_nxt = cnt_r - 4'h1;
          end
        end
        CK_EMERG: begin
          if (src_req) begin
            emerg_nxt = 1'b0;
            ck_nxt = CK_RUN;
          end
        end
        default: ck_nxt = CK_RUN;
      endcase
    end
  end

  // Clock source registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ck_r <= CK_RUN;
      src_r <= SRC_DIRECT;
      tgt_r <= SRC_DIRECT;
      cnt_r <= STEP_RST;
      emerg_r <= 1'b0;
    end else begin
      ck_r <= ck_nxt;
      src_r <= src_nxt;
      tgt_r <= tgt_nxt;
      cnt_r <= cnt_nxt;
      emerg_r <= emerg_nxt;
    end
  end

  // Output drive.
  assign mode_status = mode_r;
  assign cpu_clk_en = cpu_en_r;
  assign sys_clk_en = sys_en_r;
  assign periph_ctl = ctl_r;
  assign clk_src = src_r;
  assign clk_busy = (ck_r != CK_RUN) && (ck_r != CK_EMERG);
  assign pll_emergency = emerg_r;

  // Entry into sleep shows suspend one cycle before clocks gate.
  sequence s_sus_step;
    pm_r == PM_SUS;
  endsequence
  sequence s_gate_step;
    pm_r == PM_GATE;
  endsequence

  // Wake restores clocks one cycle before suspend is released.
  sequence s_ungate_step;
    pm_r == PM_UNGATE;
  endsequence

  a_idle_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_RUN && mode_req && mode_sel == MODE_IDLE) |=> !cpu_clk_en && pm_r == PM_IDLE)
    else $error("Idle entry did not stop the processor clock.");
  a_idle_periph: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_IDLE) |=> (periph_ctl.suspend == '0))
    else $error("Peripheral suspended during idle.");
  a_idle_clocks: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_RUN && mode_req && mode_sel == MODE_IDLE) |=> periph_ctl.clk_en == $past(periph_en))
    else $error("Peripheral clocks gated on idle entry.");
  a_idle_refuse: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_IDLE && !wake_idle) |=> pm_r == PM_IDLE && mode_status == MODE_IDLE)
    else $error("Idle left without a wake event.");
  a_idle_wake: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_IDLE && wake.watchdog) |=> pm_r == PM_RUN && cpu_clk_en)
    else $error("Idle did not wake on watchdog.");
  a_sleep_wake: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_SLEEP && wake_sleep) |=> ##2 pm_r == PM_RUN)
    else $error("Sleep did not return to run.");
  a_entry_order: assert property (@(posedge sys_clk) disable iff (rst)
    s_sus_step |=> s_gate_step)
    else $error("Shut-down skipped the gating step.");
  a_wake_order: assert property (@(posedge sys_clk) disable iff (rst)
    s_ungate_step |=> pm_r == PM_RESUME && $stable(periph_ctl.suspend) && cpu_clk_en)
    else $error("Suspend released before clocks returned.");
  a_deep_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_GATE && mode_r == MODE_DEEP) |=> !sys_clk_en && periph_ctl.clk_en == '0)
    else $error("Deep sleep entry left a clock running.");
  a_suspend_first: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_GATE && mode_r == MODE_SLEEP) |-> periph_ctl.suspend == ~sleep_en)
    else $error("Clocks gated before suspend.");
  a_deep_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_DEEP && !wake.ext_wake) |=> !sys_clk_en && pm_r == PM_DEEP)
    else $error("Deep sleep left without external wake.");
  a_req_run_only: assert property (@(posedge sys_clk) disable iff (rst)
    (pm_r == PM_SLEEP && !wake_sleep) |=> $stable(mode_status))
    else $error("Mode changed outside run.");
  a_pll_failsafe: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_src == SRC_PLL && osc_lost) |=> pll_emergency && clk_src == SRC_PRESCALE)
    else $error("PLL loss did not trigger emergency.");
  a_switch_settle: assert property (@(posedge sys_clk) disable iff (rst)
    (ck_r == CK_SWITCH && !(clk_src == SRC_PLL && !pll_locked)) |=> clk_busy [*4])
    else $error("Clock switch did not settle.");

endmodule

`default_nettype wire

// file: tb/clk_gen_model.sv
`timescale 1ns/1ps
`default_nettype none

// Clock generator stand-in: lock builds after reset and drops on a commanded fault.
module clk_gen_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fault,
  output logic pll_locked,
  output logic pll_freq_bad,
  output logic osc_lost
);
  logic [1:0] lock_cnt_r;

  // Lock needs a few cycles to settle, so a sequencer that skips the wait is exposed.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_cnt_r <= 2'h0;
    end else if (fault) begin
      lock_cnt_r <= 2'h0;
    end else if (lock_cnt_r != 2'h3) begin
      lock_cnt_r <= lock_cnt_r + 2'h1;
    end
  end

  // A lost input clock shows as lost lock together with both alarms.
  assign pll_locked = (lock_cnt_r == 2'h3);
  assign pll_freq_bad = fault;
  assign osc_lost = fault;
endmodule

`default_nettype wire

// file: tb/power_mode_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller_bench;
  import pwr_pkg::*;
  logic sys_clk, rst, mode_req, src_req, fault;
  logic [1:0] mode_sel, src_sel, mode_status, clk_src;
  logic [NUM_PERIPH-1:0] periph_en, sleep_en, periph_busy;
  wake_t wake;
  logic pll_locked, pll_freq_bad, osc_lost, cpu_clk_en, sys_clk_en, clk_busy, pll_emergency;
  periph_ctl_t periph_ctl;
  int err_total, tests_run;

  power_mode_controller u_dut (.sys_clk(sys_clk), .rst(rst), .mode_req(mode_req),
    .mode_sel(mode_sel), .periph_en(periph_en), .sleep_en(sleep_en),
    .periph_busy(periph_busy), .wake(wake), .src_req(src_req), .src_sel(src_sel),
    .pll_locked(pll_locked), .pll_freq_bad(pll_freq_bad), .osc_lost(osc_lost),
    .mode_status(mode_status), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .periph_ctl(periph_ctl), .clk_src(clk_src), .clk_busy(clk_busy),
    .pll_emergency(pll_emergency));
  clk_gen_model u_clk_gen (.sys_clk(sys_clk), .rst(rst), .fault(fault),
    .pll_locked(pll_locked), .pll_freq_bad(pll_freq_bad), .osc_lost(osc_lost));

  // The clock toggles every half period of 25 ns.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Compares a vector result and counts the outcome.
  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a single flag through the vector comparison.
  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({7'h00, got}, {7'h00, exp});
  endtask

  // Pulses a mode request for one cycle.
  task automatic req_mode(input logic [1:0] m);
    mode_sel = m;
    mode_req = 1'b1;
    @(negedge sys_clk);
    mode_req = 1'b0;
  endtask

  // Waits a bounded time for the reported mode.
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 8 && mode_status !== m; i++) @(negedge sys_clk);
  endtask

  // Requests a clock source and waits a bounded time for the switch to finish.
  task automatic sw_src(input logic [1:0] s);
    src_sel = s;
    src_req = 1'b1;
    @(negedge sys_clk);
    src_req = 1'b0;
    for (int i = 0; i < 20 && clk_busy !== 1'b0; i++) @(negedge sys_clk);
  endtask

  // Reset state, then run-mode clock enables follow configuration and demand.
  task automatic t_run();
    chk_vec(mode_status, MODE_RUN);
    chk_bit(cpu_clk_en, 1'b1);
    chk_vec(clk_src, SRC_DIRECT);
    chk_bit(pll_emergency, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk_vec(periph_ctl.clk_en, 8'h30);
    chk_vec(periph_ctl.suspend, 8'h00);
  endtask

  // Idle stops the CPU only, refuses new requests and wakes on NMI edge or interrupt.
  task automatic t_idle();
    req_mode(MODE_IDLE);
    wait_mode(MODE_IDLE);
    chk_bit(cpu_clk_en, 1'b0);
    chk_vec(periph_ctl.clk_en, 8'hF0);
    chk_vec(periph_ctl.suspend, 8'h00);
    req_mode(MODE_SLEEP);
    repeat (3) @(negedge sys_clk);
    chk_vec(mode_status, MODE_IDLE);
    wake.nmi_n = 1'b0;
    wait_mode(MODE_RUN);
    wake.nmi_n = 1'b1;
    chk_bit(cpu_clk_en, 1'b1);
    req_mode(MODE_IDLE);
    wait_mode(MODE_IDLE);
    wake.irq_any = 1'b1;
    wait_mode(MODE_RUN);
    wake.irq_any = 1'b0;
    chk_vec(mode_status, MODE_RUN);
    req_mode(MODE_IDLE);
    wait_mode(MODE_IDLE);
    wake.watchdog = 1'b1;
    wait_mode(MODE_RUN);
    wake.watchdog = 1'b0;
    chk_bit(cpu_clk_en, 1'b1);
  endtask

  // Sleep suspends all but the sleep set, then a watchdog event restores run mode.
  task automatic t_sleep();
    periph_busy = 8'hFF;
    req_mode(MODE_SLEEP);
    wait_mode(MODE_SLEEP);
    @(negedge sys_clk);
    chk_vec(periph_ctl.suspend, 8'h6F);
    chk_vec(periph_ctl.clk_en, 8'hF0);
    @(negedge sys_clk);
    chk_vec(periph_ctl.suspend, 8'h6F);
    chk_vec(periph_ctl.clk_en, 8'h90);
    wake.irq_periph = 8'h01;
    repeat (3) @(negedge sys_clk);
    wake.irq_periph = 8'h00;
    chk_vec(mode_status, MODE_SLEEP);
    wake.watchdog = 1'b1;
    wait_mode(MODE_RUN);
    wake.watchdog = 1'b0;
    chk_vec(periph_ctl.suspend, 8'h00);
    chk_vec(periph_ctl.clk_en, 8'hF0);
    req_mode(MODE_SLEEP);
    repeat (3) @(negedge sys_clk);
    wake.irq_periph = 8'h10;
    wait_mode(MODE_RUN);
    wake.irq_periph = 8'h00;
    chk_vec(mode_status, MODE_RUN);
  endtask

  // A reset during sleep returns the block to run mode with its reset values.
  task automatic t_reset();
    req_mode(MODE_SLEEP);
    repeat (3) @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_vec(mode_status, MODE_RUN);
    chk_vec(periph_ctl.suspend, 8'h00);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_bit(cpu_clk_en, 1'b1);
    chk_vec(periph_ctl.clk_en, 8'hF0);
  endtask

  // Deep sleep stops the system clock and ignores all but the external wake.
  task automatic t_deep();
    req_mode(MODE_DEEP);
    wait_mode(MODE_DEEP);
    repeat (3) @(negedge sys_clk);
    chk_bit(sys_clk_en, 1'b0);
    wake.watchdog = 1'b1;
    repeat (4) @(negedge sys_clk);
    wake.watchdog = 1'b0;
    chk_vec(mode_status, MODE_DEEP);
    wake.ext_wake = 1'b1;
    wait_mode(MODE_RUN);
    wake.ext_wake = 1'b0;
    chk_bit(sys_clk_en, 1'b1);
  endtask

  // Source switching, then a PLL fault forces the emergency fallback.
  task automatic t_clk();
    sw_src(SRC_PLL);
    chk_vec(clk_src, SRC_PLL);
    fault = 1'b1;
    for (int i = 0; i < 10 && pll_emergency !== 1'b1; i++) @(negedge sys_clk);
    chk_bit(pll_emergency, 1'b1);
    chk_vec(clk_src, SRC_PRESCALE);
    fault = 1'b0;
    sw_src(SRC_PRESCALE);
    chk_bit(pll_emergency, 1'b0);
    chk_vec(clk_src, SRC_PRESCALE);
    sw_src(SRC_DIRECT);
    chk_vec(clk_src, SRC_DIRECT);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: inputs start quiet, reset is held for ten cycles.
  initial begin
    err_total = 0;
    tests_run = 0;
    rst = 1'b1;
    mode_req = 1'b0;
    mode_sel = MODE_RUN;
    src_req = 1'b0;
    src_sel = SRC_DIRECT;
    fault = 1'b0;
    periph_en = 8'hF0;
    sleep_en = 8'h90;
    periph_busy = 8'h3C;
    wake = '0;
    wake.nmi_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    t_run();
    t_idle();
    t_sleep();
    t_deep();
    t_reset();
    t_clk();
    complete_run();
  end

  // A hang is cut short long after the hundred or so cycles the tests need.
  initial begin
    #2000000;
    err_total++;
    complete_run();
  end
endmodule

`default_nettype wire
